// file: logic/dpo_pixel_out.sv
// Deserializer pixel output stage with white balance tables and link monitoring
`include "dpo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dpo_pixel_out
  import dpo_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            srst,
  // Link side (foreign domain)
  input  wire logic            link_clk,
  input  wire dpo_pixel_type   link_pixel,
  input  wire logic            link_err,
  input  wire logic [6:0]      cable_fault,
  input  wire logic            power_down_pin_n,
  input  wire logic            strobe_edge_select,
  // Control bits
  input  wire logic            edge_override_en,
  input  wire logic            edge_override_val,
  input  wire logic            osc_en,
  input  wire logic [1:0]      osc_freq_sel,
  input  wire logic            wb_en,
  input  wire logic            wb_reload_en,
  input  wire logic            post_table_dither,
  input  wire logic            spread_spectrum_gen,
  input  wire logic            low_freq_range,
  input  wire logic [2:0]      spread_code,
  input  wire logic            err_cnt_clr,
  // Table access
  input  wire dpo_lut_req_type lut_req,
  output logic [7:0]           lut_rdata,
  output logic                 lut_rvalid,
  // Status
  output logic                 cable_detected,
  output logic [4:0]           link_err_cnt,
  output logic                 lock,
  output logic                 sleep,
  output logic                 osc_active,
  output logic [4:0]           spread_dev_tenths,
  output logic [11:0]          spread_ramp,
  // Panel side
  output logic                 pclk_out,
  output dpo_pixel_type        pix_out
);

  localparam int SW = $bits(dpo_pixel_type) + 11;
  localparam logic [15:0] STOP_CNT = 16'(`DPO_STOP_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SW-1:0] sync1_q, sync2_q;
  logic          lclk_s, lerr_s, pdb_s, esel_s;
  logic [6:0]    fault_s;
  dpo_pixel_type pix_s;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {link_clk, link_err, power_down_pin_n, strobe_edge_select,
                  cable_fault, link_pixel};
      sync2_q <= sync1_q;
    end
  end

  assign {lclk_s, lerr_s, pdb_s, esel_s, fault_s, pix_s} = sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised link clock and error strobe
  logic lclk_d1_q, lerr_d1_q;
  logic lclk_rise, lerr_rise;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lclk_d1_q <= 1'b0;
      lerr_d1_q <= 1'b0;
    end else begin
      lclk_d1_q <= lclk_s;
      lerr_d1_q <= lerr_s;
    end
  end

  assign lclk_rise = lclk_s & ~lclk_d1_q;
  assign lerr_rise = lerr_s & ~lerr_d1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link state: power-down, acquire, locked, stream sleep
  dpo_state_type state_q, state_d;
  logic [15:0]   idle_q, idle_d;
  logic [7:0]    edges_q, edges_d;

  always_comb begin
    state_d = state_q;
    idle_d  = lclk_rise ? 16'h0000 : (idle_q == STOP_CNT ? idle_q : idle_q + 16'h0001);
    edges_d = edges_q;
    case (state_q)
      DPO_ST_DOWN: begin
        edges_d = 8'h00;
        if (pdb_s) begin
          state_d = DPO_ST_ACQ;
        end
      end
      DPO_ST_ACQ: begin
        if (lclk_rise) begin
          edges_d = edges_q + 8'h01;
        end
        if (idle_q == STOP_CNT) begin
          state_d = DPO_ST_SLEEP;
        end else if (edges_q == `DPO_LOCK_EDGES) begin
          state_d = DPO_ST_LOCK;
        end
      end
      DPO_ST_LOCK: begin
        if (idle_q == STOP_CNT) begin
          state_d = DPO_ST_SLEEP;
        end
      end
      DPO_ST_SLEEP: begin
        // Relock on its own once edges return; settings are untouched
        edges_d = 8'h00;
        if (lclk_rise) begin
          state_d = DPO_ST_ACQ;
        end
      end
      default: state_d = DPO_ST_DOWN;
    endcase
    if (!pdb_s) begin
      state_d = DPO_ST_DOWN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= DPO_ST_DOWN;
      idle_q  <= 16'h0000;
      edges_q <= 8'h00;
    end else begin
      state_q <= state_d;
      idle_q  <= idle_d;
      edges_q <= edges_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault status and error counter
  logic       cable_q, cable_d;
  logic [4:0] err_q, err_d;

  always_comb begin
    cable_d = ~|fault_s;
    err_d   = err_q;
    // A new error in the clearing cycle is still counted
    if (err_cnt_clr) begin
      err_d = lerr_rise && state_q == DPO_ST_LOCK ? 5'h01 : `DPO_ERR_CNT_RST;
    end else if (lerr_rise && state_q == DPO_ST_LOCK && err_q != 5'h1f) begin
      err_d = err_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cable_q <= 1'b0;
      err_q   <= `DPO_ERR_CNT_RST;
    end else begin
      cable_q <= cable_d;
      err_q   <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // White balance tables
  logic [7:0] lut_mem [3][256];
  logic       lut_hit, wr_ok;
  logic [1:0] lut_idx;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  assign lut_hit = lut_req.page != `DPO_PAGE_CFG;
  assign lut_idx = lut_req.page - 2'h1;
  // Without reload, tables may only change while white balance is off
  assign wr_ok   = !wb_en || wb_reload_en;

  always_ff @(posedge core_clk) begin
    if (lut_req.wr && lut_hit && wr_ok) begin
      lut_mem[lut_idx][lut_req.addr] <= lut_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q  <= `DPO_LUT_RDATA_RST;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= lut_hit ? lut_mem[lut_idx][lut_req.addr] : 8'h00;
      rvalid_q <= lut_req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel capture, table lookup and post-table dither
  dpo_pixel_type cap_q, cap_d;
  logic [23:0]   bal;
  logic [23:0]   dith;
  logic [5:0]    acc_q;
  wire  [5:0]    acc_d;
  logic          cap_ev;

  assign cap_ev = lclk_rise && state_q == DPO_ST_LOCK;

  always_comb begin
    cap_d = cap_ev ? pix_s : cap_q;
  end

  // Reads and writes use separate ports, so a reload never stalls lookups
  assign bal = wb_en ? {lut_mem[0][cap_q.rgb.red], lut_mem[1][cap_q.rgb.green],
                        lut_mem[2][cap_q.rgb.blue]}
                     : cap_q.rgb;

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_dither
      logic [8:0] sum;
      assign sum = {1'b0, bal[gc*8 +: 8]} + {7'h00, acc_q[gc*2 +: 2]};
      // Carry of the dropped bits rounds up, saturating at full scale
      assign acc_d[gc*2 +: 2] = cap_ev ? sum[1:0] : acc_q[gc*2 +: 2];
      assign dith[gc*8 +: 8] = sum[8] ? 8'hfc : {sum[7:2], 2'b00};
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_q <= '0;
      acc_q <= 6'h00;
    end else begin
      cap_q <= cap_d;
      acc_q <= acc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel clock: recovered, oscillator, or held low
  logic [4:0] osc_cnt_q, osc_cnt_d;
  logic       pclk_q, pclk_d, osc_act;
  logic [4:0] osc_half;

  assign osc_half = 5'h04 << osc_freq_sel;
  assign osc_act  = osc_en && state_q == DPO_ST_SLEEP;

  always_comb begin
    osc_cnt_d = 5'h00;
    pclk_d    = 1'b0;
    if (state_q == DPO_ST_LOCK) begin
      pclk_d = lclk_d1_q;
    end else if (osc_act) begin
      osc_cnt_d = (osc_cnt_q == osc_half - 5'h01) ? 5'h00 : osc_cnt_q + 5'h01;
      pclk_d    = (osc_cnt_q == osc_half - 5'h01) ? ~pclk_q : pclk_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      osc_cnt_q <= 5'h00;
      pclk_q    <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
      pclk_q    <= pclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output launch on the selected edge, groups staggered
  logic          pclk_d1_q, edge_rise, launch;
  dpo_pixel_type out_q, out_d;
  logic [15:0]   gb_q, gb_d;
  logic [1:0]    stg_q, stg_d;
  logic [23:0]   pix_rgb;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pclk_d1_q <= 1'b0;
    end else begin
      pclk_d1_q <= pclk_q;
    end
  end

  assign edge_rise = edge_override_en ? edge_override_val : esel_s;
  assign launch    = edge_rise ? (pclk_q & ~pclk_d1_q) : (~pclk_q & pclk_d1_q);
  assign pix_rgb   = post_table_dither ? dith : bal;

  always_comb begin
    out_d = out_q;
    gb_d  = gb_q;
    stg_d = {stg_q[0], 1'b0};
    if (state_q != DPO_ST_LOCK) begin
      out_d = '0;
      gb_d  = 16'h0000;
      stg_d = 2'b00;
    end else if (launch) begin
      // Red and sync switch first; green and blue follow on later cycles
      out_d.rgb.red = pix_rgb[23:16];
      out_d.hsync   = cap_q.hsync;
      out_d.vsync   = cap_q.vsync;
      out_d.de      = cap_q.de;
      gb_d          = pix_rgb[15:0];
      stg_d         = 2'b01;
    end
    if (stg_q[0]) begin
      out_d.rgb.green = gb_q[15:8];
    end
    if (stg_q[1]) begin
      out_d.rgb.blue = gb_q[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_q <= '0;
      gb_q  <= 16'h0000;
      stg_q <= 2'b00;
    end else begin
      out_q <= out_d;
      gb_q  <= gb_d;
      stg_q <= stg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spread profile
  dpo_spread_gen u_spread (
    .core_clk            (core_clk),
    .srst                (srst),
    .spread_spectrum_gen (spread_spectrum_gen),
    .low_freq_range      (low_freq_range),
    .spread_code         (spread_code),
    .pclk_tick           (pclk_q & ~pclk_d1_q),
    .spread_dev_tenths   (spread_dev_tenths),
    .spread_ramp         (spread_ramp)
  );

  assign lut_rdata      = rdata_q;
  assign lut_rvalid     = rvalid_q;
  assign cable_detected = cable_q;
  assign link_err_cnt   = err_q;
  assign lock           = state_q == DPO_ST_LOCK;
  assign sleep          = state_q == DPO_ST_SLEEP;
  assign osc_active     = osc_act;
  assign pclk_out       = pclk_q;
  assign pix_out        = out_q;

endmodule

`default_nettype wire

// file: logic/dpo_regs.svh
// Constants of the pixel output stage: offsets, fields, resets and timing counts
`ifndef DPO_REGS_SVH
`define DPO_REGS_SVH

// Control-bus locations of the status and control fields
`define DPO_CABLE_STAT_ADDR  8'h1c
`define DPO_CABLE_DET_BIT    0
`define DPO_ERR_CNT_ADDR     8'h41
`define DPO_ERR_CNT_MSB      4
`define DPO_OSC_CTL_ADDR     8'h02
`define DPO_OSC_EN_BIT       5
`define DPO_WB_CTL_ADDR      8'h2a
`define DPO_WB_PAGE_MSB      7
`define DPO_WB_EN_BIT        5
`define DPO_WB_RELOAD_BIT    4

// Table pages
`define DPO_PAGE_CFG         2'h0
`define DPO_PAGE_RED         2'h1
`define DPO_PAGE_GREEN       2'h2
`define DPO_PAGE_BLUE        2'h3

// Reset values
`define DPO_ERR_CNT_RST      5'h00
`define DPO_LUT_RDATA_RST    8'h00

// Timing
`define DPO_CLK_PERIOD_PS    4000
`define DPO_STOP_TIME_NS     1000
`define DPO_STOP_CYCLES      ((`DPO_STOP_TIME_NS * 1000) / `DPO_CLK_PERIOD_PS)
`define DPO_LOCK_EDGES       8'h10
`define DPO_STAGGER_CYCLES   2

// Spread modulation periods in pixel clocks, by low-frequency range
`define DPO_MOD_LF_SLOW      12'd628
`define DPO_MOD_LF_FAST      12'd388
`define DPO_MOD_HF_SLOW      12'd2168
`define DPO_MOD_HF_FAST      12'd1300

`endif

// file: logic/dpo_pkg.sv
// Types shared by the pixel output stage
package dpo_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dpo_rgb_type;

  typedef struct packed {
    dpo_rgb_type rgb;
    logic        hsync;
    logic        vsync;
    logic        de;
  } dpo_pixel_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpo_lut_req_type;

  typedef enum logic [3:0] {
    DPO_ST_DOWN  = 4'b0001,
    DPO_ST_ACQ   = 4'b0010,
    DPO_ST_LOCK  = 4'b0100,
    DPO_ST_SLEEP = 4'b1000
  } dpo_state_type;

endpackage

// file: logic/dpo_spread_gen.sv
// Spread-spectrum profile generator: deviation and triangular modulation ramp
`include "dpo_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dpo_spread_gen
  import dpo_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Control
  input  wire logic       spread_spectrum_gen,
  input  wire logic       low_freq_range,
  input  wire logic [2:0] spread_code,
  input  wire logic       pclk_tick,
  // Profile
  output logic [4:0]      spread_dev_tenths,
  output logic [11:0]     spread_ramp
);

  // Deviation in tenths of a percent, either side of nominal
  function automatic logic [4:0] dev_lookup(input logic lf, input logic [2:0] code);
    logic [4:0] dev;
    dev = 5'h19;
    case ({lf, code})
      4'h8: dev = 5'h05;
      4'h9: dev = 5'h0d;
      4'ha: dev = 5'h12;
      4'hc: dev = 5'h07;
      4'hd: dev = 5'h0c;
      4'he: dev = 5'h14;
      4'h0: dev = 5'h09;
      4'h1: dev = 5'h0c;
      4'h2: dev = 5'h13;
      4'h4: dev = 5'h07;
      4'h5: dev = 5'h0d;
      4'h6: dev = 5'h14;
      default: dev = 5'h19;
    endcase
    return dev;
  endfunction

  logic [11:0] period;
  logic [11:0] cnt_q, cnt_d;
  logic [4:0]  dev_q, dev_d;
  logic [11:0] ramp_q, ramp_d;

  always_comb begin
    if (low_freq_range) begin
      period = spread_code[2] ? `DPO_MOD_LF_FAST : `DPO_MOD_LF_SLOW;
    end else begin
      period = spread_code[2] ? `DPO_MOD_HF_FAST : `DPO_MOD_HF_SLOW;
    end
  end

  always_comb begin
    cnt_d  = cnt_q;
    ramp_d = ramp_q;
    dev_d  = spread_spectrum_gen ? dev_lookup(low_freq_range, spread_code) : 5'h00;
    if (!spread_spectrum_gen) begin
      cnt_d  = 12'h000;
      ramp_d = 12'h000;
    end else if (pclk_tick) begin
      cnt_d  = (cnt_q >= period - 12'h001) ? 12'h000 : cnt_q + 12'h001;
      // Triangle: up for the first half of the period, down for the second
      ramp_d = (cnt_q < (period >> 1)) ? cnt_q : period - cnt_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q  <= 12'h000;
      ramp_q <= 12'h000;
      dev_q  <= 5'h00;
    end else begin
      cnt_q  <= cnt_d;
      ramp_q <= ramp_d;
      dev_q  <= dev_d;
    end
  end

  assign spread_dev_tenths = dev_q;
  assign spread_ramp       = ramp_q;

endmodule

`default_nettype wire

// file: sim/dpo_pixel_out_checker.sv
// Concurrent checks on the ports of the pixel output stage
`timescale 1ns/1ps
`default_nettype none

module dpo_pixel_out_checker
  import dpo_pkg::*;
(
  // Clock and reset
  input wire logic            core_clk,
  input wire logic            srst,
  // Stimulus seen at the ports
  input wire dpo_lut_req_type lut_req,
  input wire logic [6:0]      cable_fault,
  input wire logic            power_down_pin_n,
  input wire logic            osc_en,
  input wire logic            err_cnt_clr,
  // Responses
  input wire logic [7:0]      lut_rdata,
  input wire logic            lut_rvalid,
  input wire logic            cable_detected,
  input wire logic [4:0]      link_err_cnt,
  input wire logic            lock,
  input wire logic            sleep,
  input wire logic            osc_active,
  input wire logic            pclk_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Cycles the fallback clock has held its level; its longest half period is 32
  logic       pclk_last_q;
  logic [5:0] osc_still_q;

  always_ff @(posedge core_clk) begin
    pclk_last_q <= pclk_out;
    osc_still_q <= (osc_active && pclk_out == pclk_last_q) ? osc_still_q + 6'h01 : 6'h00;
  end

  a_read_answered: assert property (lut_req.rd |=> lut_rvalid)
    else $error("table read not answered");
  a_no_stray_valid: assert property (!lut_req.rd |=> !lut_rvalid)
    else $error("valid without read");
  a_page_zero_empty: assert property (lut_req.rd && lut_req.page == 2'h0 |=> lut_rdata == 8'h00)
    else $error("page 0 returned table data");
  a_fault_clears: assert property ((cable_fault != 7'h00) [*5] |-> !cable_detected)
    else $error("cable reported while faulted");
  a_clean_detects: assert property ((cable_fault == 7'h00) [*5] |-> cable_detected)
    else $error("cable missing without fault");
  a_pin_powers_down: assert property (!power_down_pin_n [*5] |-> !lock && !sleep)
    else $error("link alive in power-down");
  a_sleep_unlocked: assert property (sleep |-> !lock)
    else $error("locked while asleep");
  a_osc_fallback: assert property (sleep && osc_en |-> osc_active && osc_still_q < 6'h21)
    else $error("oscillator not engaged");
  a_err_held_unlocked: assert property (!lock && !err_cnt_clr |=> $stable(link_err_cnt))
    else $error("errors counted while unlocked");
  a_err_single_step: assert property (!err_cnt_clr |=> link_err_cnt == $past(link_err_cnt)
    || link_err_cnt == $past(link_err_cnt) + 5'h01)
    else $error("error count jumped");
  a_err_cleared: assert property (err_cnt_clr |=> link_err_cnt <= 5'h01)
    else $error("error count not cleared");

  c_locked: cover property (lock);
  c_osc_running: cover property (osc_active);
  c_err_saturated: cover property (link_err_cnt == 5'h1f);
endmodule

bind dpo_pixel_out dpo_pixel_out_checker u_chk (.core_clk, .srst, .lut_req, .cable_fault,
  .power_down_pin_n, .osc_en, .err_cnt_clr, .lut_rdata, .lut_rvalid, .cable_detected,
  .link_err_cnt, .lock, .sleep, .osc_active, .pclk_out);

`default_nettype wire

// file: sim/dpo_panel_model.sv
// Panel model: samples pixels on the edge opposite the launch edge
`timescale 1ns/1ps
`default_nettype none

module dpo_panel_model
  import dpo_pkg::*;
(
  // Panel pins
  input wire logic          pclk,
  input wire dpo_pixel_type pix,
  // Bench control
  input wire logic          rise_launch,
  input wire logic          watch,
  // Observations
  output var dpo_pixel_type seen_pix,
  output var int            n_bad
);
  initial n_bad = 0;
  // Sampling on the far edge gives data half a period to settle
  always @(pclk) begin
    if (pclk !== rise_launch) seen_pix <= pix;
  end
  // A change in the wrong clock phase would race the panel's sampling edge
  always @(pix) if (watch && pclk_level_bad(pclk, rise_launch)) n_bad++;

  function automatic logic pclk_level_bad(input logic c, input logic r);
    return c !== r;
  endfunction
endmodule

`default_nettype wire

// file: sim/test_dpo_pixel_out.sv
// Self-checking bench for the pixel output stage
`timescale 1ns/1ps
`default_nettype none

module test_dpo_pixel_out
  import dpo_pkg::*;
;
  localparam time DLY = 0.5;
  // Low-range deviation per spread code, tenths of a percent
  localparam logic [4:0] DEV_LF [8] = '{5'h05, 5'h0d, 5'h12, 5'h19, 5'h07, 5'h0c, 5'h14, 5'h19};

  logic            core_clk = 1'b0, srst = 1'b1, power_down_pin_n = 1'b1;
  logic            link_clk = 1'b0, link_run = 1'b0, link_err = 1'b0, err_cnt_clr = 1'b0;
  logic            strobe_edge_select = 1'b1, edge_override_en = 1'b0, edge_override_val = 1'b0;
  logic            osc_en = 1'b0, wb_en = 1'b0, wb_reload_en = 1'b0, post_table_dither = 1'b0;
  logic            spread_spectrum_gen = 1'b0, low_freq_range = 1'b0;
  logic [1:0]      osc_freq_sel = 2'h0;
  logic [2:0]      spread_code = 3'h0;
  logic [6:0]      cable_fault = 7'h00;
  dpo_pixel_type   link_pixel = '0;
  dpo_lut_req_type lut_req = '0;
  logic [7:0]      lut_rdata;
  logic            lut_rvalid, cable_detected, lock, sleep, osc_active, pclk_out, last_pclk;
  logic [4:0]      link_err_cnt, spread_dev_tenths;
  logic [11:0]     spread_ramp;
  dpo_pixel_type   pix_out, seen;
  logic            watch = 1'b0, rise_mode = 1'b1;
  int              n_errors = 0, tests_run = 0, cycles = 0, n_bad, t_r, t_g, t_b, toggles, pk;

  dpo_pixel_out dut (.*);
  dpo_panel_model panel (.pclk(pclk_out), .pix(pix_out), .rise_launch(rise_mode),
    .watch(watch), .seen_pix(seen), .n_bad(n_bad));

  ////////////////////////////////////////////////////////////////////////////////
  always #2 core_clk = ~core_clk;
  // Link clock has its own phase and rests low while the stream is stopped
  initial begin
    #1.3;
    forever #24 link_clk = link_run ? ~link_clk : 1'b0;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #DLY;
  endtask

  // Request stays up until the next call so back-to-back accesses need no idle
  task automatic lut_op(input logic w, input logic [1:0] pg, input logic [7:0] a, d);
    lut_req = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
    step(1);
  endtask

  task automatic lut_rd(input logic [1:0] pg, input logic [7:0] a, e);
    lut_op(1'b0, pg, a, 8'h00);
    check(24'(lut_rvalid), 24'h1);
    check(24'(lut_rdata), 24'(e));
  endtask

  // Red and green distinct per entry, blue six-bit with low bits clear
  function automatic logic [7:0] lut_val(input logic [1:0] pg, input logic [7:0] a);
    return pg == 2'h1 ? ~a : pg == 2'h2 ? a ^ 8'h5a : {a[7:2], 2'b00};
  endfunction

  task automatic set_pix(input logic [23:0] c, input int n);
    @(negedge link_clk);
    link_pixel = '{rgb: c, hsync: c[0], vsync: 1'b0, de: 1'b1};
    step(n);
  endtask

  task automatic wait_lock();
    for (int i = 0; i < 800 && lock !== 1'b1; i++) step(1);
    check(24'(lock), 24'h1);
  endtask

  task automatic pulse_err(input int n);
    repeat (n) begin
      link_err = 1'b1;
      step(4);
      link_err = 1'b0;
      step(5);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(2);
    srst = 1'b0;
    for (int p = 1; p < 4; p++)
      for (int a = 0; a < 256; a++)
        lut_op(1'b1, 2'(p), 8'(a), lut_val(2'(p), 8'(a)));
    lut_op(1'b1, 2'h0, 8'h40, 8'hff);
    for (int p = 0; p < 4; p++)
      for (int a = 0; a < 256; a += 51)
        lut_rd(2'(p), 8'(a), p == 0 ? 8'h00 : lut_val(2'(p), 8'(a)));
    wb_en = 1'b1;
    lut_op(1'b1, 2'h1, 8'h10, 8'h33);
    lut_rd(2'h1, 8'h10, 8'hef);
    wb_reload_en = 1'b1;
    lut_op(1'b1, 2'h1, 8'h10, 8'h33);
    lut_rd(2'h1, 8'h10, 8'h33);
    lut_op(1'b1, 2'h1, 8'h10, 8'hef);
    lut_req = '0;
    wb_en = 1'b0;
    link_run = 1'b1;
    wait_lock();
    set_pix(24'h123456, 40);
    check(24'(pix_out.rgb), 24'h123456);
    wb_en = 1'b1;
    step(30);
    check(24'(pix_out.rgb), 24'hed6e54);
    post_table_dither = 1'b1;
    set_pix(24'h818181, 40);
    check({pix_out.rgb.red[1:0], pix_out.rgb.green[1:0], pix_out.rgb.blue[1:0]}, 24'h0);
    {wb_en, post_table_dither} = 2'b00;
    set_pix(24'h000000, 40);
    set_pix(24'hffffff, 0);
    {t_r, t_g, t_b} = '0;
    for (int i = 1; i < 40; i++) begin
      step(1);
      if (t_r == 0 && pix_out.rgb.red === 8'hff) t_r = i;
      if (t_g == 0 && pix_out.rgb.green === 8'hff) t_g = i;
      if (t_b == 0 && pix_out.rgb.blue === 8'hff) t_b = i;
    end
    check(24'(t_g - t_r), 24'h1);
    check(24'(t_b - t_r), 24'h2);
    for (int m = 0; m < 3; m++) begin
      {strobe_edge_select, edge_override_en, edge_override_val} = {m == 0, m == 2, 1'b1};
      rise_mode = (m != 1);
      step(30);
      watch = 1'b1;
      set_pix({3{8'(8'h40 + m)}}, 40);
      check(24'(seen.rgb), {3{8'(8'h40 + m)}});
      watch = 1'b0;
    end
    check(24'(n_bad), 24'h0);
    {strobe_edge_select, edge_override_en} = 2'b10;
    for (int i = 0; i < 7; i++) begin
      cable_fault = 7'h01 << i;
      step(5);
      check(24'(cable_detected), 24'h0);
      cable_fault = 7'h00;
      step(5);
      check(24'(cable_detected), 24'h1);
    end
    pulse_err(5);
    check(24'(link_err_cnt), 24'h05);
    pulse_err(30);
    check(24'(link_err_cnt), 24'h1f);
    err_cnt_clr = 1'b1;
    step(1);
    err_cnt_clr = 1'b0;
    step(1);
    check(24'(link_err_cnt), 24'h00);
    osc_en = 1'b1;
    link_run = 1'b0;
    for (int i = 0; i < 400 && sleep !== 1'b1; i++) step(1);
    check(24'({sleep, lock, osc_active}), 24'h5);
    for (int s = 0; s < 2; s++) begin
      osc_freq_sel = 2'(s);
      step(70);
      toggles = 0;
      for (int i = 0; i < 64; i++) begin
        last_pclk = pclk_out;
        step(1);
        if (pclk_out !== last_pclk) toggles++;
      end
      check(24'(toggles >= (16 >> s) - 1 && toggles <= (16 >> s) + 1), 24'h1);
    end
    pulse_err(1);
    check(24'(link_err_cnt), 24'h00);
    lut_rd(2'h2, 8'h20, 8'h7a);
    lut_req = '0;
    link_run = 1'b1;
    wait_lock();
    set_pix(24'habcdef, 40);
    check(24'(sleep), 24'h0);
    check(24'(pix_out.rgb), 24'habcdef);
    power_down_pin_n = 1'b0;
    step(6);
    check(24'({lock, sleep}), 24'h0);
    power_down_pin_n = 1'b1;
    wait_lock();
    {spread_spectrum_gen, low_freq_range} = 2'b11;
    for (int c = 0; c < 8; c++) begin
      spread_code = 3'(c);
      step(3);
      check(24'(spread_dev_tenths), 24'(DEV_LF[c]));
    end
    // Ramp peaks at half the modulation period: 314 or 194 pixel clocks
    for (int c = 3; c < 8; c += 4) begin
      spread_code = 3'(c);
      spread_spectrum_gen = 1'b0;
      step(2);
      spread_spectrum_gen = 1'b1;
      pk = 0;
      for (int i = 0; i < 4000; i++) begin
        step(1);
        if (spread_ramp > pk) pk = spread_ramp;
      end
      check(24'(pk), c < 4 ? 24'h13a : 24'hc2);
    end
    {low_freq_range, spread_code} = 4'h0;
    step(3);
    check(24'(spread_dev_tenths), 24'h09);
    wrap_up();
  end
endmodule

`default_nettype wire
